// file: rtl/ssr_pkg.sv
package ssr_pkg;
  // register offsets on the apb port
  localparam int          SSR_ADDR_W    = 4;
  localparam logic [3:0]  SSR_OFF_CTRL  = 4'h0;
  localparam logic [3:0]  SSR_OFF_BAUD  = 4'h4;
  localparam logic [3:0]  SSR_OFF_STAT  = 4'h8;
  localparam logic [3:0]  SSR_OFF_DATA  = 4'hC;

  // control register field positions
  localparam int SSR_B_SERIAL_PORT_ENABLE = 0;   // serial_port_enable
  localparam int SSR_B_SYNC = 1;   // synchronous_select
  localparam int SSR_B_CLOCK_SOURCE_SELECT = 2;   // clock_source_select
  localparam int SSR_B_SINGLE_RECEIVE_ENABLE = 3;   // single_receive_enable
  localparam int SSR_B_CONTINUOUS_RECEIVE_ENABLE = 4;   // continuous_receive_enable
  localparam int SSR_B_RX9  = 5;   // nine_bit_receive_select
  localparam int SSR_B_RECEIVE_INTERRUPT_ENABLE = 6;   // receive_interrupt_enable
  localparam int SSR_B_HBS  = 7;   // high_baud_select
  localparam int SSR_B_WBS  = 8;   // wide_baud_select

  // status register field positions
  localparam int SSR_B_RECEIVE_FLAG = 0;   // receive_flag
  localparam int SSR_B_OVERRUN_ERROR_FLAG = 1;   // overrun_error_flag
  localparam int SSR_B_NINTH_RECEIVED_BIT = 2;   // ninth_received_bit
  localparam int SSR_B_BUSY = 3;   // character in progress

  // reset values
  localparam logic [8:0]  SSR_CTRL_RST  = 9'h000;
  localparam logic [15:0] SSR_BAUD_RST  = 16'h0004;

  // character sizes and fifo depth
  localparam logic [3:0]  SSR_BITS8     = 4'h8;
  localparam logic [3:0]  SSR_BITS9     = 4'h9;
  localparam int          SSR_FIFO_DEPTH = 2;

  // peer clock half period in pclk cycles
  localparam int          SSR_PEER_HALF = 4;

  // bits per character for the chosen size
  function automatic logic [3:0] ssr_nbits(input logic nine);
    return nine ? SSR_BITS9 : SSR_BITS8;
  endfunction
endpackage

// file: rtl/ssr_link_if.sv
interface ssr_link_if;
  // per-end drive and enable of the two shared lines
  logic dev_ck_o;
  logic dev_ck_oe;
  logic dev_dt_o;
  logic dev_dt_oe;
  logic peer_ck_o;
  logic peer_ck_oe;
  logic peer_dt_o;
  logic peer_dt_oe;
  // resolved line levels, idle low when nobody drives
  logic clock_line;
  logic data_line;

  assign clock_line = dev_ck_oe  ? dev_ck_o  :
                      peer_ck_oe ? peer_ck_o : 1'b0;
  assign data_line  = dev_dt_oe  ? dev_dt_o  :
                      peer_dt_oe ? peer_dt_o : 1'b0;

  modport dev (
    output dev_ck_o,
    output dev_ck_oe,
    output dev_dt_o,
    output dev_dt_oe,
    input  clock_line,
    input  data_line
  );
  modport peer (
    output peer_ck_o,
    output peer_ck_oe,
    output peer_dt_o,
    output peer_dt_oe,
    input  clock_line,
    input  data_line
  );
endinterface

// file: rtl/ssr_sync2.sv
module ssr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // two-flop synchroniser, first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// file: rtl/ssr_rx_dev.sv
// Decided for this implementation: the register offsets and register access over APB.
module ssr_rx_dev
  import ssr_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [SSR_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       rx_irq,
  ssr_link_if.dev                    link
);
  typedef enum logic [1:0] {SSR_IDLE, SSR_HIGH, SSR_LOW} ssr_mst_t;

  // control fields
  logic        serial_port_enable;
  logic        sync_sel;
  logic        clock_source_select;
  logic        single_receive_enable;
  logic        continuous_receive_enable;
  logic        rx9;
  logic        receive_interrupt_enable;
  logic        hbs;
  logic        wbs;
  logic [15:0] divisor;

  // receive state
  ssr_mst_t    state;
  ssr_mst_t    next_state;
  logic [16:0] cnt;
  logic [16:0] half;
  logic        tick;
  logic        ck_out;
  logic [3:0]  bitcnt;
  logic [8:0]  shreg;
  logic [8:0]  fifo [SSR_FIFO_DEPTH];
  logic [1:0]  count;
  logic        overrun_error_flag;
  logic        overrun_error_flag_single;
  logic [1:0]  ln_s;
  logic        ck_d;

  logic        master_act;
  logic        slave_act;
  logic        rx_req;
  logic        take;
  logic        done;
  logic        dbit;
  logic [8:0]  full_char;
  logic [8:0]  new_char;
  logic        fifo_full;
  logic        push;
  logic        pop;
  logic        acc;
  logic        wr_ctrl;
  logic        wr_baud;
  logic        rd_data;

  // clock cycles per half period minus one
  function automatic logic [16:0] half_cycles(input logic [15:0] div,
                                              input logic        wide,
                                              input logic        hi);
    logic [15:0] d;
    d = wide ? div : {8'h00, div[7:0]};
    return hi ? {1'b0, d} : {d, 1'b1};
  endfunction

  function automatic logic reg_hit(input logic [SSR_ADDR_W-1:0] a);
    return a == SSR_OFF_CTRL || a == SSR_OFF_BAUD ||
           a == SSR_OFF_STAT || a == SSR_OFF_DATA;
  endfunction

  // link inputs cross into pclk
  ssr_sync2 #(.W(2)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({link.clock_line, link.data_line}),
    .q     (ln_s)
  );

  // bus strobes, one wait state per transfer
  assign acc     = psel && penable && pready;
  assign wr_ctrl = acc && pwrite && paddr == SSR_OFF_CTRL;
  assign wr_baud = acc && pwrite && paddr == SSR_OFF_BAUD;
  assign rd_data = acc && !pwrite && paddr == SSR_OFF_DATA;

  assign master_act = serial_port_enable && sync_sel && clock_source_select;
  assign slave_act  = serial_port_enable && sync_sel && !clock_source_select;
  // reception wanted and not blocked by overrun
  assign rx_req     = serial_port_enable && sync_sel && (single_receive_enable || continuous_receive_enable) && !overrun_error_flag;

  // half period from the baud settings
  assign half = half_cycles(divisor, wbs, hbs);
  assign tick = state != SSR_IDLE && cnt == half;

  // trailing (falling) edge takes one bit
  assign dbit = ln_s[0];
  assign take = master_act ? (state == SSR_HIGH && tick)
                           : (slave_act && rx_req && ck_d && !ln_s[1]);
  assign done = take && bitcnt == ssr_nbits(rx9) - 4'h1;

  // nine or eight bits, lsb first
  assign full_char = {dbit, shreg[8:1]};
  assign new_char  = rx9 ? full_char : {1'b0, full_char[8:1]};

  // pop on data read; full unless popped now
  assign pop       = rd_data && count != 2'h0;
  assign fifo_full = count == 2'h2 && !pop;
  assign push      = done && !fifo_full;

  always_comb begin
    next_state = state;
    case (state)
      SSR_IDLE: if (master_act && rx_req) next_state = SSR_HIGH;
      SSR_HIGH: if (tick) next_state = SSR_LOW;
      SSR_LOW:  if (tick) next_state = SSR_HIGH;
      default:  next_state = SSR_IDLE;
    endcase
    // stop at once when enables drop
    if (!(master_act && rx_req)) begin
      next_state = SSR_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= SSR_IDLE;
      ck_out <= 1'b0;
    end else begin
      state  <= next_state;
      ck_out <= next_state == SSR_HIGH;
    end
  end

  // baud divider count within a phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 17'h0_0000;
    end else if (state == SSR_IDLE || tick) begin
      cnt <= 17'h0_0000;
    end else begin
      cnt <= cnt + 17'h0_0001;
    end
  end

  // slave edge history of synced clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_d <= 1'b0;
    end else begin
      ck_d <= ln_s[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitcnt <= 4'h0;
      shreg  <= 9'h000;
    end else if (!rx_req) begin
      bitcnt <= 4'h0;
    end else if (take) begin
      bitcnt <= done ? 4'h0 : bitcnt + 4'h1;
      shreg  <= full_char;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= 2'h0;
      fifo[0] <= 9'h000;
      fifo[1] <= 9'h000;
    end else if (!serial_port_enable) begin
      count <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          fifo[count[0]] <= new_char;
          count          <= count + 2'h1;
        end
        2'b01: begin
          fifo[0] <= fifo[1];
          count   <= count - 2'h1;
        end
        2'b11: begin
          if (count == 2'h1) begin
            fifo[0] <= new_char;
          end else begin
            fifo[0] <= fifo[1];
            fifo[1] <= new_char;
          end
        end
        default: count <= count;
      endcase
    end
  end

  // overrun set and clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_flag        <= 1'b0;
      overrun_error_flag_single <= 1'b0;
    end else if (done && fifo_full) begin
      overrun_error_flag        <= 1'b1;
      overrun_error_flag_single <= single_receive_enable && !continuous_receive_enable;
    end else if (!serial_port_enable) begin
      overrun_error_flag <= 1'b0;
    end else if (overrun_error_flag_single ? rd_data : !continuous_receive_enable) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // control registers, software write after hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {wbs, hbs, receive_interrupt_enable, rx9, continuous_receive_enable, single_receive_enable, clock_source_select, sync_sel, serial_port_enable} <=
        SSR_CTRL_RST;
      divisor <= SSR_BAUD_RST;
    end else begin
      // single enable ends with its character
      if (done && single_receive_enable) begin
        single_receive_enable <= 1'b0;
      end
      if (wr_ctrl) begin
        serial_port_enable     <= pwdata[SSR_B_SERIAL_PORT_ENABLE];
        sync_sel <= pwdata[SSR_B_SYNC];
        clock_source_select     <= pwdata[SSR_B_CLOCK_SOURCE_SELECT];
        single_receive_enable     <= pwdata[SSR_B_SINGLE_RECEIVE_ENABLE];
        continuous_receive_enable     <= pwdata[SSR_B_CONTINUOUS_RECEIVE_ENABLE];
        rx9      <= pwdata[SSR_B_RX9];
        receive_interrupt_enable     <= pwdata[SSR_B_RECEIVE_INTERRUPT_ENABLE];
        hbs      <= pwdata[SSR_B_HBS];
        wbs      <= pwdata[SSR_B_WBS];
      end
      if (wr_baud) begin
        divisor <= pwdata[15:0];
      end
    end
  end

  // apb answer, read data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !reg_hit(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          SSR_OFF_CTRL: prdata[8:0] <=
            {wbs, hbs, receive_interrupt_enable, rx9, continuous_receive_enable, single_receive_enable, clock_source_select, sync_sel, serial_port_enable};
          SSR_OFF_BAUD: prdata[15:0] <= divisor;
          SSR_OFF_STAT: begin
            prdata[SSR_B_RECEIVE_FLAG] <= count != 2'h0;
            prdata[SSR_B_OVERRUN_ERROR_FLAG] <= overrun_error_flag;
            prdata[SSR_B_NINTH_RECEIVED_BIT] <= fifo[0][8];
            prdata[SSR_B_BUSY] <= bitcnt != 4'h0;
          end
          // low eight bits of oldest character
          SSR_OFF_DATA: prdata[7:0] <= fifo[0][7:0];
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // interrupt request from flag and enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= receive_interrupt_enable && (count != 2'h0 || push);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.dev_ck_oe <= 1'b0;
    end else begin
      link.dev_ck_oe <= master_act;
    end
  end
  assign link.dev_ck_o  = ck_out;
  // receive only, data line never driven
  assign link.dev_dt_o  = 1'b0;
  assign link.dev_dt_oe = 1'b0;
endmodule

// file: rtl/ssr_peer_end.sv
module ssr_peer_end
  import ssr_pkg::*;
#(
  parameter int HALF = SSR_PEER_HALF
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       be_master,
  input  wire logic       nine_bit,
  input  wire logic [8:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  ssr_link_if.peer        link
);
  typedef enum logic [1:0] {SSP_IDLE, SSP_LOW, SSP_HIGH} ssr_peer_st_t;

  ssr_peer_st_t state;
  logic [15:0]  cnt;
  logic         tick;
  logic [8:0]   shreg;
  logic [3:0]   left;
  logic         busy;
  logic         ck_s;
  logic         ck_d;
  logic         lead;
  logic         trail;

  ssr_sync2 #(.W(1)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (link.clock_line),
    .q     (ck_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_d <= 1'b0;
    end else begin
      ck_d <= ck_s;
    end
  end

  assign tick  = state != SSP_IDLE && cnt == 16'(HALF - 1);
  // leading edge moves data, trailing counts the bit
  assign lead  = be_master ? (state == SSP_LOW && tick) : (ck_s && !ck_d);
  assign trail = be_master ? (state == SSP_HIGH && tick) : (!ck_s && ck_d);

  // own clock as master, half period HALF cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SSP_IDLE;
      cnt   <= 16'h0000;
    end else begin
      cnt <= (state == SSP_IDLE || tick) ? 16'h0000 : cnt + 16'h0001;
      case (state)
        SSP_IDLE: if (be_master && busy) state <= SSP_LOW;
        SSP_LOW:  if (tick) state <= SSP_HIGH;
        // stop after the character's last bit
        SSP_HIGH: if (tick) state <= (left == 4'h1) ? SSP_IDLE : SSP_LOW;
        default:  state <= SSP_IDLE;
      endcase
    end
  end

  // character load and shift out, lsb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg          <= 9'h000;
      left           <= 4'h0;
      busy           <= 1'b0;
      tx_ready       <= 1'b0;
      link.peer_dt_o <= 1'b0;
    end else begin
      tx_ready <= !busy && !(tx_valid && tx_ready);
      if (!busy && tx_valid && tx_ready) begin
        shreg <= tx_data;
        left  <= ssr_nbits(nine_bit);
        busy  <= 1'b1;
      end else if (busy && lead) begin
        link.peer_dt_o <= shreg[0];
        shreg          <= {1'b0, shreg[8:1]};
      end else if (busy && trail) begin
        left <= left - 4'h1;
        busy <= left != 4'h1;
      end
    end
  end

  // clock enable follows the chosen role, data line always driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.peer_ck_o  <= 1'b0;
      link.peer_ck_oe <= 1'b0;
      link.peer_dt_oe <= 1'b0;
    end else begin
      // clock rises with the data change, falls at trail
      link.peer_ck_o  <= (state == SSP_LOW && tick) ||
                         (state == SSP_HIGH && !tick);
      link.peer_ck_oe <= be_master;
      link.peer_dt_oe <= 1'b1;
    end
  end
endmodule

// file: bench/ssr_link_sva.sv
module ssr_link_sva #(
  parameter int H  = 6,
  parameter int PH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dev_ck_o,
  input wire logic dev_ck_oe,
  input wire logic dev_dt_oe,
  input wire logic peer_ck_oe,
  input wire logic peer_dt_oe,
  input wire logic clock_line,
  input wire logic data_line
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] hi_cnt;
  logic [7:0] lo_cnt;
  logic [7:0] half;

  // half period of whichever end makes the clock
  assign half = dev_ck_oe ? 8'(H) : 8'(PH);

  // cycles the clock line has stayed high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 8'h00;
    end else if (!clock_line) begin
      hi_cnt <= 8'h00;
    end else if (hi_cnt != 8'hFF) begin
      hi_cnt <= hi_cnt + 8'h01;
    end
  end

  // cycles low, saturating so a long idle counts as enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt <= 8'hFF;
    end else if (clock_line) begin
      lo_cnt <= 8'h00;
    end else if (lo_cnt != 8'hFF) begin
      lo_cnt <= lo_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_data_quiet: assert property (!dev_dt_oe)
    else $error("device drove the data line");
  chk_slave_ck_off: assert property (peer_ck_oe |-> !dev_ck_oe)
    else $error("device drove clock while peer is master");
  chk_ck_idle_off: assert property (!dev_ck_oe |-> !dev_ck_o)
    else $error("clock output active while not master");
  chk_high_span: assert property ($fell(clock_line) |-> hi_cnt == half)
    else $error("clock high phase has wrong length");
  chk_low_span: assert property ($rose(clock_line) |-> lo_cnt >= half)
    else $error("clock low phase too short");
  chk_sample_hold: assert property (
    $fell(clock_line) |=> $stable(data_line) [*3])
    else $error("data moved right after trailing edge");
  chk_lead_change: assert property (
    $past(presetn) && $changed(data_line) |-> clock_line)
    else $error("data changed while clock low");
  chk_peer_drives: assert property ($past(presetn) |-> peer_dt_oe)
    else $error("transmitting end released data line");
endmodule

// file: bench/test_sync_serial_receive_unit.sv
`define SSR_CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("unexpected at %0t: got %h want %h", $time, (g), (e)); \
    end \
  end

module test_sync_serial_receive_unit import ssr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [SSR_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  rx_irq;
  logic                  be_master;
  logic                  nine_bit;
  logic [8:0]            tx_data;
  logic                  tx_valid;
  logic                  tx_ready;
  logic                  ck_q;
  logic                  last_err;
  logic [31:0]           rd;
  int                    nfall;
  int                    err_count;
  int                    compares;

  ssr_link_if i_ssr_link_if ();

  ssr_rx_dev i_ssr_rx_dev (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rx_irq  (rx_irq),
    .link    (i_ssr_link_if.dev)
  );

  ssr_peer_end #(.HALF(SSR_PEER_HALF)) i_ssr_peer_end (
    .pclk      (pclk),
    .presetn   (presetn),
    .be_master (be_master),
    .nine_bit  (nine_bit),
    .tx_data   (tx_data),
    .tx_valid  (tx_valid),
    .tx_ready  (tx_ready),
    .link      (i_ssr_link_if.peer)
  );

  ssr_link_sva #(.H(6), .PH(SSR_PEER_HALF)) i_ssr_link_sva (
    .pclk       (pclk),
    .presetn    (presetn),
    .dev_ck_o   (i_ssr_link_if.dev_ck_o),
    .dev_ck_oe  (i_ssr_link_if.dev_ck_oe),
    .dev_dt_oe  (i_ssr_link_if.dev_dt_oe),
    .peer_ck_oe (i_ssr_link_if.peer_ck_oe),
    .peer_dt_oe (i_ssr_link_if.peer_dt_oe),
    .clock_line (i_ssr_link_if.clock_line),
    .data_line  (i_ssr_link_if.data_line)
  );

  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // count trailing edges seen on the clock line
  always @(posedge pclk) begin
    ck_q <= i_ssr_link_if.clock_line;
    if (ck_q && !i_ssr_link_if.clock_line) begin
      nfall <= nfall + 1;
    end
  end

  task automatic wrap_up;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one apb transfer, request held until pready
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `SSR_CHK(rd, e)
  endtask

  // read until the masked field matches, bounded
  task automatic poll(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0000_0000);
      n++;
    end while ((rd & m) !== v && n < 300);
    `SSR_CHK(rd & m, v)
  endtask

  // peer transmit requests, valid held across characters
  task automatic send(input logic [8:0] c0, input logic [8:0] c1,
                      input logic [8:0] c2, input int n);
    logic [8:0] q [3];
    q = '{c0, c1, c2};
    tx_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_data <= q[i];
      do @(posedge pclk); while (tx_ready !== 1'b1);
    end
    tx_valid <= 1'b0;
  endtask

  task automatic t_regs;
    rchk(SSR_OFF_CTRL, 32'h0000_0000);
    rchk(SSR_OFF_BAUD, 32'h0000_0004);
    wr(4'h2, 32'hFFFF_FFFF);
    `SSR_CHK(last_err, 1'b1)
    wr(SSR_OFF_STAT, 32'h0000_000F);
    rchk(SSR_OFF_STAT, 32'h0000_0000);
    wr(SSR_OFF_BAUD, 32'h0000_0002);
    rchk(SSR_OFF_BAUD, 32'h0000_0002);
  endtask

  // master single receive three times, third overruns
  task automatic t_single;
    logic [8:0] ch [3];
    int b;
    ch = '{9'h0A5, 9'h03C, 9'h00F};
    wr(SSR_OFF_CTRL, 32'h0000_0047);
    for (int i = 0; i < 3; i++) begin
      b = nfall;
      fork
        send(ch[i], 9'h000, 9'h000, 1);
        wr(SSR_OFF_CTRL, 32'h0000_004F);
      join
      poll(SSR_OFF_CTRL, 32'h0000_0008, 32'h0000_0000);
      `SSR_CHK(nfall - b, 8)
      if (i == 0) `SSR_CHK(rx_irq, 1'b1)
    end
    rchk(SSR_OFF_CTRL, 32'h0000_0047);
    rchk(SSR_OFF_STAT, 32'h0000_0003);
    rchk(SSR_OFF_DATA, 32'h0000_00A5);
    rchk(SSR_OFF_STAT, 32'h0000_0001);
    rchk(SSR_OFF_DATA, 32'h0000_003C);
    rchk(SSR_OFF_STAT, 32'h0000_0000);
    `SSR_CHK(rx_irq, 1'b0)
  endtask

  // nine-bit, both enables, continuous overrun
  task automatic t_cont;
    int b;
    nine_bit <= 1'b1;
    wr(SSR_OFF_BAUD, 32'h0000_0105);
    wr(SSR_OFF_CTRL, 32'h0000_00A7);
    fork
      send(9'h1A5, 9'h05A, 9'h0C3, 3);
      wr(SSR_OFF_CTRL, 32'h0000_00BF);
    join
    poll(SSR_OFF_STAT, 32'h0000_0002, 32'h0000_0002);
    rchk(SSR_OFF_CTRL, 32'h0000_00B7);
    b = nfall;
    repeat (60) @(posedge pclk);
    `SSR_CHK(nfall - b, 0)
    rchk(SSR_OFF_STAT, 32'h0000_0007);
    rchk(SSR_OFF_DATA, 32'h0000_00A5);
    rchk(SSR_OFF_STAT, 32'h0000_0003);
    rchk(SSR_OFF_DATA, 32'h0000_005A);
    rchk(SSR_OFF_STAT, 32'h0000_0002);
    wr(SSR_OFF_CTRL, 32'h0000_0087);
    rchk(SSR_OFF_STAT, 32'h0000_0000);
    nine_bit <= 1'b0;
  endtask

  // peer makes the clock, device listens as slave
  task automatic t_slave;
    int b;
    wr(SSR_OFF_CTRL, 32'h0000_0013);
    be_master <= 1'b1;
    b = nfall;
    send(9'h03C, 9'h000, 9'h000, 1);
    poll(SSR_OFF_STAT, 32'h0000_0001, 32'h0000_0001);
    rchk(SSR_OFF_DATA, 32'h0000_003C);
    `SSR_CHK(nfall - b, 8)
    wr(SSR_OFF_CTRL, 32'h0000_0000);
    be_master <= 1'b0;
  endtask

  // continuous enable dropped mid character, then reset
  task automatic t_abort;
    int b;
    wr(SSR_OFF_BAUD, 32'h0000_0002);
    wr(SSR_OFF_CTRL, 32'h0000_0107);
    b = nfall;
    fork
      send(9'h0FF, 9'h000, 9'h000, 1);
      wr(SSR_OFF_CTRL, 32'h0000_0117);
    join
    repeat (3) @(negedge i_ssr_link_if.clock_line);
    @(posedge pclk);
    wr(SSR_OFF_CTRL, 32'h0000_0107);
    repeat (40) @(posedge pclk);
    `SSR_CHK(nfall - b, 3)
    rchk(SSR_OFF_STAT, 32'h0000_0000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(SSR_OFF_CTRL, 32'h0000_0000);
    rchk(SSR_OFF_BAUD, 32'h0000_0004);
  endtask

  // main sequence
  // link pins here are digital only, no analog select
  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = 32'h0000_0000;
    be_master = 1'b0;
    nine_bit  = 1'b0;
    tx_data   = 9'h000;
    tx_valid  = 1'b0;
    ck_q      = 1'b0;
    nfall     = 0;
    err_count = 0;
    compares  = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_single;
    t_cont;
    t_slave;
    t_abort;
    wrap_up;
  end

  // watchdog against a hang
  initial begin
    #400_000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule
